// ===== sccu_pkg.sv
`default_nettype none
package sccu_pkg;
	localparam int ADDR_W = 8;

	// Register byte offsets
	localparam logic [7:0] REG_KEY = 8'h00;
	localparam logic [7:0] REG_CYCLE = 8'h04;
	localparam logic [7:0] REG_ACQ = 8'h08;
	localparam logic [7:0] REG_TRIM = 8'h0c;
	localparam logic [7:0] REG_FORMAT = 8'h10;
	localparam logic [7:0] REG_EXTRA = 8'h14;
	localparam logic [7:0] REG_INTERVAL = 8'h18;
	localparam logic [7:0] REG_UNIT = 8'h1c;
	localparam logic [7:0] REG_PLAUS = 8'h20;
	localparam logic [7:0] REG_PULLUP = 8'h24;
	localparam logic [7:0] REG_RDELAY = 8'h28;
	localparam logic [7:0] REG_TRIGGER = 8'h2c;
	localparam logic [7:0] REG_DEVID = 8'h30;
	localparam logic [7:0] REG_STATUS = 8'h34;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	localparam logic [31:0] KEY_QUERY = 32'h0000_0000;
	localparam logic [31:0] KEY_USER = 32'h0000_0001;
	localparam logic [31:0] KEY_TOP_ACCESS_LEVEL = 32'h0000_1267;

	localparam logic [15:0] CYCLE_MAX = 16'h7530;
	localparam logic [15:0] CYCLE_RESET = 16'h0002;
	localparam logic [15:0] CYCLE_UNIT_MS = 16'h000a;
	localparam logic [15:0] ACQ_MAX = 16'h03e8;
	localparam logic [15:0] ACQ_RESET = 16'h000a;
	localparam logic [8:0] TRIM_MAX = 9'h167;
	localparam logic [9:0] FULL_TURN = 10'h168;
	localparam logic [1:0] FORMAT_STD = 2'h0;
	localparam logic [1:0] FORMAT_ALT = 2'h2;
	localparam int EXTRA_DIGITS = 5;
	localparam logic [2:0] EXTRA_CODE_MAX = 3'h4;
	localparam logic [13:0] INTERVAL_MIN = 14'h000a;
	localparam logic [13:0] INTERVAL_MAX = 14'h2710;
	localparam logic [13:0] INTERVAL_RESET = 14'h0064;
	localparam logic [1:0] UNIT_MAX = 2'h3;
	localparam logic [1:0] PLAUS_MIN_USER = 2'h2;
	localparam logic [1:0] PLAUS_RESET = 2'h2;
	localparam logic [2:0] PULLUP_MAX = 3'h5;
	localparam logic [9:0] RDELAY_MAX = 10'h3e8;
	localparam logic [9:0] RDELAY_RESET = 10'h005;
	localparam logic [2:0] TRIG_MAX = 3'h4;
	localparam logic [6:0] DEVID_MAX = 7'h63;
	localparam logic [6:0] DEVID_ANY = 7'h63;

	// Speed factors in Q10: m/s, km/h, miles/h, knots
	localparam logic [11:0] SCALE_MS = 12'h400;
	localparam logic [11:0] SCALE_KMH = 12'he66;
	localparam logic [11:0] SCALE_MPH = 12'h8f3;
	localparam logic [11:0] SCALE_KN = 12'h7c3;

	localparam logic [2:0] PU_OFF = 3'h0;
	localparam logic [2:0] PU_ON = 3'h1;
	localparam logic [2:0] PU_ON_WARN = 3'h2;
	localparam logic [2:0] PU_OFF_WARN = 3'h3;
	localparam logic [2:0] PU_ON_FAULT = 3'h4;
	localparam logic [2:0] PU_OFF_FAULT = 3'h5;

	localparam logic [2:0] TRIG_OFF = 3'h0;
	localparam logic [2:0] TRIG_RISE = 3'h1;
	localparam logic [2:0] TRIG_FALL = 3'h2;
	localparam logic [2:0] TRIG_HIGH = 3'h3;
	localparam logic [2:0] TRIG_LOW = 3'h4;

	localparam int CLK_FREQ_HZ = 200_000_000;
	localparam int TICK_TIME_MS = 1;
	localparam int MS_PER_S = 1000;
	localparam int DIV_W = 24;

	typedef enum logic [1:0] {LVL_QUERY, LVL_USER, LVL_TOP_ACCESS_LEVEL} sccu_level_type;

	typedef struct packed {
		logic [8:0] raw_direction;
		logic [15:0] raw_speed;
	} sccu_meas_type;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic [7:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		sccu_level_type level;
		logic dirty;
		logic save_req;
		logic [15:0] cycle;
		logic [15:0] acq;
		logic [8:0] trim;
		logic [1:0] alt_fmt;
		logic [14:0] extra;
		logic [13:0] interval;
		logic [1:0] unit;
		logic [1:0] plaus;
		logic [2:0] pullup_mode;
		logic [9:0] rdelay;
		logic [2:0] trig;
		logic [6:0] devid;
		logic [DIV_W-1:0] ms_div;
		logic ms_tick;
		logic [18:0] meas_ms;
		logic meas_start;
		logic [13:0] out_ms;
		logic tel_due;
		logic tel_drop;
		logic line_s1;
		logic line_s2;
		logic line_prev;
		logic rd_busy;
		logic [9:0] rd_ms;
		logic reply_go;
		logic [8:0] heading;
		logic [17:0] speed;
		logic id_hit;
		logic pullup_en;
		logic [14:0] append_codes;
	} sccu_state_type;
endpackage : sccu_pkg
`default_nettype wire

// ===== sccu_top.sv
// Functional notes
// - Key 0 selects query, 1 user, 4711 administrator access level.
// - Lowering the access level saves parameters changed in the session.
// - Every restart returns the device to query access level.
// - Measure cycle period counts 10 ms units, range 0 to 30000.
// - Raising acquisition time to the cycle period or more lengthens the cycle period, never shortens it.
// - Cycle period defaults to 2, that is 20 ms.
// - Heading trim 0 to 359 degrees is added to every direction.
// - Output format accepts only 0 and 2, default 0.
// - Five extra-value digits append values, left to right, except NMEA.
// - Extra codes: 0 none, 1 pressure, 2 sea pressure, 3 temperature, 4 supply.
// - Free-running telegram every N ms, N 10 to 10000, default 100.
// - Interval 0 sends telegrams only on control-line trigger.
// - Telegram due while link busy is dropped; latest values are repeated.
// - Speed unit scales output: m/s, km/h, miles/h, knots; default m/s.
// - Plausibility levels stack; default 2; only 2 and 3 writable.
// - Pull-up modes 0 to 5: off, on, warning and malfunction driven.
// - Pull-up is off during energy saving sleep.
// - Reply start is delayed 0 to 1000 ms, default 5.
// - Commands carry a two-digit identifier; identifier 99 is always answered.
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sccu_top
	import sccu_pkg::*;
#(
	parameter int CLK_PER_MS = (CLK_FREQ_HZ / MS_PER_S) * TICK_TIME_MS
) (
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
	input wire logic [2:0] s_axi_awprot, // Write protection, ignored
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
	input wire logic [2:0] s_axi_arprot, // Read protection, ignored
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic ctrl_line, // Control line level from pin
	input wire logic link_busy, // Serial transmitter still sending
	input wire logic sleep_active, // Energy saving sleep in force
	input wire logic wind_warning, // Wind warning threshold exceeded
	input wire logic malfunction, // General malfunction present
	input wire logic cmd_received, // Pulse: a command was parsed
	input wire logic [6:0] cmd_id, // Identifier of the parsed command
	input wire logic telegram_is_nmea, // Current telegram is the NMEA one
	input wire sccu_meas_type meas, // Latest measured direction and speed
	output logic measure_start, // Pulse: begin a four-path cycle
	output logic telegram_due, // Pulse: send a telegram now
	output logic telegram_drop, // Pulse: telegram discarded, link busy
	output logic reply_go, // Pulse: reply may start
	output logic id_match, // Command identifier addresses this unit
	output logic save_request, // Pulse: store parameters in non-volatile memory
	output logic line_pullup, // Control line pull-up enable
	output logic [8:0] heading, // Trimmed direction in degrees
	output logic [17:0] speed_scaled, // Speed in selected unit, input scale
	output logic [14:0] append_codes, // Extra-value digits for this telegram
	output logic alt_telegram_format, // Alternative format for telegram 9
	output logic [1:0] plausibility_level // Active plausibility level
);
	localparam logic [DIV_W-1:0] MS_LAST = DIV_W'(CLK_PER_MS - 1);

	sccu_state_type s;
	sccu_state_type next_s;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic extra_ok(input logic [31:0] v);
		logic ok;
		ok = (v[31:15] == 17'h00000);
		for (int i = 0; i < EXTRA_DIGITS; i++) begin
			if (v[3*i +: 3] > EXTRA_CODE_MAX) begin
				ok = 1'b0;
			end
		end
		return ok;
	endfunction : extra_ok

	function automatic logic [31:0] reg_read(input sccu_state_type st, input logic [7:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		unique case (a)
			REG_KEY: r[1:0] = st.level;
			REG_CYCLE: r[15:0] = st.cycle;
			REG_ACQ: r[15:0] = st.acq;
			REG_TRIM: r[8:0] = st.trim;
			REG_FORMAT: r[1:0] = st.alt_fmt;
			REG_EXTRA: r[14:0] = st.extra;
			REG_INTERVAL: r[13:0] = st.interval;
			REG_UNIT: r[1:0] = st.unit;
			REG_PLAUS: r[1:0] = st.plaus;
			REG_PULLUP: r[2:0] = st.pullup_mode;
			REG_RDELAY: r[9:0] = st.rdelay;
			REG_TRIGGER: r[2:0] = st.trig;
			REG_DEVID: r[6:0] = st.devid;
			REG_STATUS: r[7:0] = {st.pullup_en, st.rd_busy, st.line_s2, st.id_hit,
				st.dirty, 1'b0, st.level};
			default: r = 32'h0000_0000;
		endcase
		return r;
	endfunction : reg_read

	function automatic logic mapped(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a <= REG_STATUS);
	endfunction : mapped

	always_comb begin
		logic [31:0] wv;
		logic [1:0] resp;
		logic top_access_level;
		logic fire;
		logic trig_hit;
		logic [9:0] dir_sum;
		logic [27:0] prod;
		logic [11:0] factor;
		sccu_level_type new_level;
		wv = 32'h0000_0000;
		resp = RESP_OKAY;
		fire = 1'b0;
		trig_hit = 1'b0;
		dir_sum = 10'h000;
		prod = 28'h0000000;
		factor = SCALE_MS;
		new_level = LVL_QUERY;
		next_s = s;
		top_access_level = (s.level == LVL_TOP_ACCESS_LEVEL);
		next_s.save_req = 1'b0;
		next_s.ms_tick = 1'b0;
		next_s.meas_start = 1'b0;
		next_s.tel_due = 1'b0;
		next_s.tel_drop = 1'b0;
		next_s.reply_go = 1'b0;

		// Write channel: address and data may come in either order
		if (s_axi_awvalid && s.awready) begin
			next_s.waddr = s_axi_awaddr;
			next_s.awready = 1'b0;
		end
		if (s_axi_wvalid && s.wready) begin
			next_s.wdata = s_axi_wdata;
			next_s.wstrb = s_axi_wstrb;
			next_s.wready = 1'b0;
		end
		if (!s.awready && !s.wready && !s.bvalid) begin
			wv = merge(reg_read(s, s.waddr), s.wdata, s.wstrb);
			if (!mapped(s.waddr)) begin
				resp = RESP_DECERR;
			end else if (s.waddr == REG_KEY) begin
				if (wv == KEY_QUERY) begin
					new_level = LVL_QUERY;
				end else if (wv == KEY_USER) begin
					new_level = LVL_USER;
				end else if (wv == KEY_TOP_ACCESS_LEVEL) begin
					new_level = LVL_TOP_ACCESS_LEVEL;
				end else begin
					resp = RESP_SLVERR;
					new_level = s.level;
				end
				next_s.level = new_level;
				if (new_level < s.level && s.dirty) begin
					next_s.save_req = 1'b1;
					next_s.dirty = 1'b0;
				end
			end else if (!top_access_level || s.waddr == REG_STATUS) begin
				resp = RESP_SLVERR;
			end else begin
				unique case (s.waddr)
					REG_CYCLE: if (wv <= 32'(CYCLE_MAX)) next_s.cycle = wv[15:0];
						else resp = RESP_SLVERR;
					REG_ACQ: if (wv <= 32'(ACQ_MAX)) begin
						next_s.acq = wv[15:0];
						if (wv[15:0] > s.acq && 32'(s.cycle) * 32'(CYCLE_UNIT_MS) <= wv) begin
							next_s.cycle = 16'(wv[15:0] / CYCLE_UNIT_MS + 16'h0001);
						end
					end else resp = RESP_SLVERR;
					REG_TRIM: if (wv <= 32'(TRIM_MAX)) next_s.trim = wv[8:0];
						else resp = RESP_SLVERR;
					REG_FORMAT: if (wv == 32'(FORMAT_STD) || wv == 32'(FORMAT_ALT))
						next_s.alt_fmt = wv[1:0];
						else resp = RESP_SLVERR;
					REG_EXTRA: if (extra_ok(wv)) next_s.extra = wv[14:0];
						else resp = RESP_SLVERR;
					REG_INTERVAL: if (wv == 32'h0 || (wv >= 32'(INTERVAL_MIN)
						&& wv <= 32'(INTERVAL_MAX))) next_s.interval = wv[13:0];
						else resp = RESP_SLVERR;
					REG_UNIT: if (wv <= 32'(UNIT_MAX)) next_s.unit = wv[1:0];
						else resp = RESP_SLVERR;
					REG_PLAUS: if (wv >= 32'(PLAUS_MIN_USER) && wv <= 32'h3)
						next_s.plaus = wv[1:0];
						else resp = RESP_SLVERR;
					REG_PULLUP: if (wv <= 32'(PULLUP_MAX)) next_s.pullup_mode = wv[2:0];
						else resp = RESP_SLVERR;
					REG_RDELAY: if (wv <= 32'(RDELAY_MAX)) next_s.rdelay = wv[9:0];
						else resp = RESP_SLVERR;
					REG_TRIGGER: if (wv <= 32'(TRIG_MAX)) next_s.trig = wv[2:0];
						else resp = RESP_SLVERR;
					REG_DEVID: if (wv <= 32'(DEVID_MAX)) next_s.devid = wv[6:0];
						else resp = RESP_SLVERR;
					default: resp = RESP_DECERR;
				endcase
				if (resp == RESP_OKAY) begin
					next_s.dirty = 1'b1;
				end
			end
			next_s.bvalid = 1'b1;
			next_s.bresp = resp;
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
			next_s.awready = 1'b1;
			next_s.wready = 1'b1;
		end

		// Read channel: data returned at the address handshake edge
		if (s_axi_arvalid && s.arready) begin
			next_s.arready = 1'b0;
			next_s.rvalid = 1'b1;
			next_s.rdata = reg_read(s, s_axi_araddr);
			next_s.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
		end
		if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
			next_s.arready = 1'b1;
		end

		// Millisecond enable
		if (s.ms_div >= MS_LAST) begin
			next_s.ms_div = '0;
			next_s.ms_tick = 1'b1;
		end else begin
			next_s.ms_div = s.ms_div + 1'b1;
		end

		// Measurement cycle timer, start to start
		if (s.ms_tick) begin
			if (s.meas_ms + 19'h00001 >= 19'(s.cycle) * 19'(CYCLE_UNIT_MS)) begin
				next_s.meas_ms = 19'h00000;
				next_s.meas_start = 1'b1;
			end else begin
				next_s.meas_ms = s.meas_ms + 19'h00001;
			end
		end

		// Control line synchroniser and trigger decode
		next_s.line_s1 = ctrl_line;
		next_s.line_s2 = s.line_s1;
		next_s.line_prev = s.line_s2;
		unique case (s.trig)
			TRIG_RISE: trig_hit = s.line_s2 && !s.line_prev;
			TRIG_FALL: trig_hit = !s.line_s2 && s.line_prev;
			TRIG_HIGH: trig_hit = s.line_s2 && s.ms_tick;
			TRIG_LOW: trig_hit = !s.line_s2 && s.ms_tick;
			default: trig_hit = 1'b0;
		endcase

		// Telegram scheduling; the interval timer is separate from the cycle timer
		if (s.interval == 14'h0000) begin
			next_s.out_ms = 14'h0000;
			fire = trig_hit;
		end else if (s.ms_tick) begin
			if (s.out_ms + 14'h0001 >= s.interval) begin
				next_s.out_ms = 14'h0000;
				fire = 1'b1;
			end else begin
				next_s.out_ms = s.out_ms + 14'h0001;
			end
		end
		if (fire) begin
			next_s.tel_due = !link_busy;
			next_s.tel_drop = link_busy;
		end

		// Reply hold-off after a command
		if (cmd_received) begin
			next_s.rd_busy = 1'b1;
			next_s.rd_ms = s.rdelay;
			next_s.id_hit = (cmd_id == s.devid) || (cmd_id == DEVID_ANY);
		end else if (s.rd_busy) begin
			if (s.rd_ms == 10'h000) begin
				next_s.rd_busy = 1'b0;
				next_s.reply_go = 1'b1;
			end else if (s.ms_tick) begin
				next_s.rd_ms = s.rd_ms - 10'h001;
			end
		end

		// Heading trim, wrapped to one turn
		dir_sum = {1'b0, meas.raw_direction} + {1'b0, s.trim};
		next_s.heading = (dir_sum >= FULL_TURN) ? 9'(dir_sum - FULL_TURN) : dir_sum[8:0];

		// Unit scaling in Q10 fixed point
		unique case (s.unit)
			2'h1: factor = SCALE_KMH;
			2'h2: factor = SCALE_MPH;
			2'h3: factor = SCALE_KN;
			default: factor = SCALE_MS;
		endcase
		prod = 28'(meas.raw_speed) * 28'(factor);
		next_s.speed = prod[27:10];

		// Extra values are suppressed for the NMEA telegram
		next_s.append_codes = telegram_is_nmea ? 15'h0000 : s.extra;

		unique case (s.pullup_mode)
			PU_ON: next_s.pullup_en = 1'b1;
			PU_ON_WARN: next_s.pullup_en = wind_warning;
			PU_OFF_WARN: next_s.pullup_en = !wind_warning;
			PU_ON_FAULT: next_s.pullup_en = malfunction;
			PU_OFF_FAULT: next_s.pullup_en = !malfunction;
			default: next_s.pullup_en = 1'b0;
		endcase
		if (sleep_active) begin
			next_s.pullup_en = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.awready <= 1'b1;
			s.wready <= 1'b1;
			s.arready <= 1'b1;
			s.level <= LVL_QUERY;
			s.cycle <= CYCLE_RESET;
			s.acq <= ACQ_RESET;
			s.alt_fmt <= FORMAT_STD;
			s.interval <= INTERVAL_RESET;
			s.plaus <= PLAUS_RESET;
			s.pullup_mode <= PU_OFF;
			s.rdelay <= RDELAY_RESET;
			s.trig <= TRIG_OFF;
		end else begin
			s <= next_s;
		end
	end

	assign s_axi_awready = s.awready;
	assign s_axi_wready = s.wready;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = s.arready;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign measure_start = s.meas_start;
	assign telegram_due = s.tel_due;
	assign telegram_drop = s.tel_drop;
	assign reply_go = s.reply_go;
	assign id_match = s.id_hit;
	assign save_request = s.save_req;
	assign line_pullup = s.pullup_en;
	assign heading = s.heading;
	assign speed_scaled = s.speed;
	assign append_codes = s.append_codes;
	assign alt_telegram_format = s.alt_fmt[1];
	assign plausibility_level = s.plaus;
endmodule : sccu_top
`default_nettype wire

// ===== sccu_props.sv
`timescale 1ns/1ps
`default_nettype none
module sccu_props
	import sccu_pkg::*;
#(
	parameter int CLK_PER_MS = 200000
) (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Reset
	input wire logic s_axi_awvalid, // AW valid
	input wire logic s_axi_awready, // AW ready
	input wire logic s_axi_wvalid, // W valid
	input wire logic s_axi_wready, // W ready
	input wire logic s_axi_bvalid, // B valid
	input wire logic [ADDR_W-1:0] s_axi_araddr, // AR address
	input wire logic s_axi_arvalid, // AR valid
	input wire logic s_axi_arready, // AR ready
	input wire logic [31:0] s_axi_rdata, // R data
	input wire logic [1:0] s_axi_rresp, // R response
	input wire logic s_axi_rvalid, // R valid
	input wire logic save_request, // Save pulse
	input wire logic sleep_active, // Sleep
	input wire logic line_pullup, // Pull-up
	input wire logic link_busy, // Link busy
	input wire logic telegram_due, // Due pulse
	input wire logic telegram_drop, // Drop pulse
	input wire logic telegram_is_nmea, // NMEA telegram
	input wire logic [14:0] append_codes, // Extra digits
	input wire logic cmd_received, // Command pulse
	input wire logic [6:0] cmd_id, // Command id
	input wire logic id_match // Id match
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	wr_answer_a: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_awready ##1 s_axi_bvalid) else $error("write not answered");
	rd_answer_a: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read not answered");
	rd_unmapped_a: assert property (
		s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h34
		|=> s_axi_rresp == RESP_DECERR && s_axi_rdata == 32'h0) else $error("bad unmapped read");
	save_on_b_a: assert property (
		save_request |-> $rose(s_axi_bvalid) ##1 !save_request) else $error("stray save pulse");
	sleep_pull_a: assert property (
		sleep_active |=> !line_pullup) else $error("pull-up on in sleep");
	due_drop_a: assert property (
		telegram_due || telegram_drop |-> telegram_drop == $past(link_busy))
		else $error("due or drop mismatch");
	nmea_none_a: assert property (
		telegram_is_nmea |=> append_codes == 15'h0) else $error("extras on nmea");
	id_any_a: assert property (
		cmd_received && cmd_id == 7'h63 |=> id_match) else $error("wildcard id ignored");

	cover property (save_request);
	cover property (telegram_drop);
	cover property (cmd_received ##1 id_match);
endmodule : sccu_props
bind sccu_top sccu_props #(.CLK_PER_MS(CLK_PER_MS)) sccu_props_i (.*);
`default_nettype wire

// ===== sccu_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sccu_host_model (
	input wire logic aclk, // Clock
	output logic cmd_received, // Command pulse
	output logic [6:0] cmd_id // Command id
);
	initial begin
		cmd_received = 1'h0;
		cmd_id = 7'h0;
	end
	// Id qualifies only the pulse, then shows a changed value
	task automatic send(input logic [6:0] id);
		@(posedge aclk);
		cmd_received <= 1'h1;
		cmd_id <= id;
		@(posedge aclk);
		cmd_received <= 1'h0;
		cmd_id <= ~id;
	endtask : send
endmodule : sccu_host_model
`default_nettype wire

// ===== sensor_config_command_unit_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sensor_config_command_unit_tb_top;
	import sccu_pkg::*;
	localparam int CPM = 20;
	localparam logic [7:0] RA [11] = '{REG_CYCLE, REG_TRIM, REG_FORMAT, REG_EXTRA,
		REG_INTERVAL, REG_UNIT, REG_PLAUS, REG_PULLUP, REG_RDELAY, REG_TRIGGER, REG_DEVID};
	localparam logic [31:0] BAD [11] = '{32'h7531, 32'h168, 32'h1, 32'h5924, 32'h5,
		32'h4, 32'h1, 32'h6, 32'h3e9, 32'h5, 32'h64};
	localparam logic [31:0] GOOD [11] = '{32'h7530, 32'h167, 32'h2, 32'h4924, 32'h2710,
		32'h3, 32'h3, 32'h5, 32'h3e8, 32'h4, 32'h63};
	localparam int FAC [4] = '{SCALE_MS, SCALE_KMH, SCALE_MPH, SCALE_KN};
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic ctrl_line = 1'h0, link_busy = 1'h0, sleep_active = 1'h0;
	logic wind_warning = 1'h0, malfunction = 1'h0, telegram_is_nmea = 1'h0;
	sccu_meas_type meas = '0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, plausibility_level;
	logic [31:0] s_axi_rdata;
	logic cmd_received, measure_start, telegram_due, telegram_drop, reply_go;
	logic id_match, save_request, line_pullup, alt_telegram_format;
	logic [6:0] cmd_id;
	logic [8:0] heading;
	logic [17:0] speed_scaled;
	logic [14:0] append_codes;
	int error_cnt = 0;
	int checks = 0;
	int saves = 0;
	int model [14];

	always #2.5 aclk = ~aclk;
	sccu_top #(.CLK_PER_MS(CPM)) sccu_top_i (.*);
	sccu_host_model sccu_host_model_i (.aclk(aclk), .cmd_received(cmd_received), .cmd_id(cmd_id));
	always @(posedge aclk) if (save_request === 1'h1) saves++;

	task automatic end_of_test;
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk

	task automatic model_reset;
		model = '{default: 0};
		model[1] = 2;
		model[2] = 10;
		model[6] = 100;
		model[8] = 2;
		model[10] = 5;
	endtask : model_reset

	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		forever begin
			@(posedge aclk);
			if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
			if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid === 1'h1) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'h0;
				break;
			end
		end
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		forever begin
			@(posedge aclk);
			if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid === 1'h1) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'h0;
				break;
			end
		end
	endtask : rd

	// Reference model: accepted writes land, key reads back as level
	task automatic put(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic [1:0] r;
		wr(a, d, r);
		chk(r, e);
		if (e == RESP_OKAY && a == REG_KEY) model[0] = (d == KEY_TOP_ACCESS_LEVEL) ? 2 : d;
		else if (e == RESP_OKAY) begin
			if (a == REG_ACQ && d > model[2] && model[1] * 10 <= d) model[1] = d / 10 + 1;
			model[a >> 2] = d;
		end
	endtask : put

	task automatic get(input logic [7:0] a);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, model[a >> 2]);
		chk(r, RESP_OKAY);
	endtask : get

	task automatic get_all;
		for (int a = 0; a < 13; a++) get(8'(a * 4));
	endtask : get_all

	task automatic gap(input bit tel, output int n);
		while ((tel ? telegram_due | telegram_drop : measure_start) !== 1'h1) @(posedge aclk);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while ((tel ? telegram_due | telegram_drop : measure_start) !== 1'h1);
	endtask : gap

	task automatic wait_reply(output int n);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (reply_go !== 1'h1);
	endtask : wait_reply

	initial begin
		#200us;
		error_cnt++;
		end_of_test();
	end

	initial begin
		int n, t, d, s, x;
		logic [31:0] rv;
		logic [1:0] rr;
		logic [5:0] pv;
		void'($urandom(54));
		model_reset();
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		get_all();
		rd(8'h38, rv, rr);
		chk({rv[29:0], rr}, {30'h0, RESP_DECERR});
		put(REG_TRIM, 32'h5, RESP_SLVERR);
		put(REG_KEY, 32'h5, RESP_SLVERR);
		put(REG_KEY, KEY_USER, RESP_OKAY);
		get(REG_KEY);
		put(REG_KEY, KEY_TOP_ACCESS_LEVEL, RESP_OKAY);
		get(REG_KEY);
		put(8'h38, 32'h0, RESP_DECERR);
		put(REG_STATUS, 32'h0, RESP_SLVERR);
		for (int i = 0; i < 11; i++) begin
			put(RA[i], BAD[i], RESP_SLVERR);
			put(RA[i], GOOD[i], RESP_OKAY);
			get(RA[i]);
		end
		chk({alt_telegram_format, plausibility_level}, 3'h7);
		put(REG_CYCLE, 32'h2, RESP_OKAY);
		put(REG_ACQ, 32'h32, RESP_OKAY);
		get(REG_CYCLE);
		put(REG_ACQ, 32'h14, RESP_OKAY);
		get(REG_CYCLE);
		put(REG_KEY, KEY_USER, RESP_OKAY);
		@(posedge aclk);
		chk(saves, 1);
		aresetn <= 1'h0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		model_reset();
		get_all();
		put(REG_KEY, KEY_TOP_ACCESS_LEVEL, RESP_OKAY);
		t = $urandom_range(359);
		put(REG_TRIM, 32'(t), RESP_OKAY);
		for (int u = 0; u < 4; u++) begin
			put(REG_UNIT, 32'(u), RESP_OKAY);
			repeat (3) begin
				d = $urandom_range(359);
				s = $urandom_range(65535);
				@(posedge aclk);
				meas <= '{9'(d), 16'(s)};
				repeat (2) @(posedge aclk);
				#1;
				chk(heading, 32'((d + t) % 360));
				chk(speed_scaled, 32'((s * FAC[u]) >> 10));
			end
		end
		x = 0;
		for (int i = 0; i < 5; i++) x = x * 8 + $urandom_range(4);
		put(REG_EXTRA, 32'(x), RESP_OKAY);
		for (int k = 0; k < 2; k++) begin
			@(posedge aclk);
			telegram_is_nmea <= k[0];
			repeat (2) @(posedge aclk);
			#1;
			chk(append_codes, k ? 32'h0 : 32'(x));
		end
		for (int m = 0; m < 6; m++) begin
			put(REG_PULLUP, 32'(m), RESP_OKAY);
			for (int k = 0; k < 8; k++) begin
				@(posedge aclk);
				{sleep_active, wind_warning, malfunction} <= 3'(k);
				repeat (2) @(posedge aclk);
				#1;
				pv = {!k[0], k[0], !k[1], k[1], 2'h2};
				chk(line_pullup, pv[m] & !k[2]);
			end
		end
		@(posedge aclk);
		{sleep_active, wind_warning, malfunction} <= 3'h0;
		put(REG_CYCLE, 32'h3, RESP_OKAY);
		gap(1'h0, n);
		chk(n, 30 * CPM);
		put(REG_INTERVAL, 32'ha, RESP_OKAY);
		gap(1'h1, n);
		chk(n, 10 * CPM);
		link_busy <= 1'h1;
		gap(1'h1, n);
		chk({telegram_drop, 16'(n)}, {1'h1, 16'(10 * CPM)});
		link_busy <= 1'h0;
		put(REG_INTERVAL, 32'h0, RESP_OKAY);
		for (int m = 1; m < 5; m++) begin
			put(REG_TRIGGER, 32'(m), RESP_OKAY);
			ctrl_line <= (m == 2 || m == 4);
			repeat (10) @(posedge aclk);
			ctrl_line <= (m == 1 || m == 3);
			if (m > 2) repeat (5) @(posedge aclk);
			n = 0;
			repeat (5 * CPM) begin
				@(posedge aclk);
				if (telegram_due === 1'h1) n++;
			end
			chk(n, m > 2 ? 5 : 1);
		end
		put(REG_DEVID, 32'h7, RESP_OKAY);
		put(REG_RDELAY, 32'h0, RESP_OKAY);
		for (int i = 0; i < 3; i++) begin
			sccu_host_model_i.send(i == 0 ? 7'h7 : i == 1 ? 7'h63 : 7'h5);
			repeat (2) @(posedge aclk);
			#1;
			chk(id_match, i < 2);
		end
		repeat (10) @(posedge aclk);
		sccu_host_model_i.send(7'h7);
		wait_reply(n);
		chk(n, 2);
		put(REG_RDELAY, 32'h14, RESP_OKAY);
		sccu_host_model_i.send(7'h7);
		wait_reply(n);
		chk(n > 19 * CPM && n <= 20 * CPM + 3, 1'h1);
		end_of_test();
	end
endmodule : sensor_config_command_unit_tb_top
`default_nettype wire
